/* File: pkg/apw_defines.svh */
`ifndef APW_DEFINES_SVH
`define APW_DEFINES_SVH
// ==========================================
// register offsets
`define APW_OFS_CAPT_CTRL   12'h029
`define APW_OFS_FLAGS_LOW   12'h02c
`define APW_OFS_FLAGS_MID   12'h02d
`define APW_OFS_FLAGS_HIGH  12'h02e
`define APW_OFS_DLY_INV     12'h030
`define APW_OFS_DLY_COARSE  12'h031
`define APW_OFS_DLY_FINE    12'h032
`define APW_OFS_RAMP_CTRL   12'h033
`define APW_OFS_COARSE_EFF  12'h034
// ==========================================
// field positions
`define APW_SEL_MSB         3
`define APW_ZOOM_BIT        4
`define APW_SINGLE_BIT      5
`define APW_RAMP_EN_BIT     0
`define APW_RAMP_FAST_BIT   1
`define APW_RAMP_BUSY_BIT   2
// ==========================================
// reset values
`define APW_CAPT_CTRL_RST   8'h10
`define APW_DLY_RST         8'h00
`define APW_FLAGS_RST       24'h800001
// ==========================================
// timing counts
`define APW_SLOW_PERIOD     9'd256
`define APW_FAST_PERIOD     9'd64
`define APW_FRAME_LEN       8'd8
`define APW_NUM_POS         24
`endif

/* File: pkg/apw_pkg.sv */
package apw_pkg;
   // ==========================================
   // types
   typedef enum logic {RAMP_IDLE, RAMP_MOVE} apw_ramp_state_t;
   typedef logic [23:0] apw_flags_t;
endpackage

/* File: pkg/apw_win_if.sv */
`timescale 1ns/1ns
interface apw_win_if;
   logic [23:0] taps;
   logic [3:0]  sel;
   logic        single;
   logic [23:0] flags;
   logic        ref_edge;
   modport win  (input taps, input sel, input single, output flags, output ref_edge);
   modport core (output taps, output sel, output single, input flags, input ref_edge);
endinterface

/* File: rtl/apw_window.sv */
`timescale 1ns/1ns
`include "apw_defines.svh"
module apw_window (
   // clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // window link
   apw_win_if.win    w
);
   // ==========================================
   // position detector
   apw_pkg::apw_flags_t risk;
   apw_pkg::apw_flags_t flags;
   logic                seen;
   logic                capt_q;
   logic                capt;

   assign risk[0] = 1'b1;
   assign risk[23] = 1'b1;
   // a position is at risk when its sample disagrees with a neighbour
   genvar g;
   generate
      for (g = 1; g < `APW_NUM_POS - 1; g++) begin : g_pos
         assign risk[g] = (w.taps[g] ^ w.taps[g-1]) | (w.taps[g] ^ w.taps[g+1]);
      end
   endgenerate
   // only a sample that holds an edge says where the reference sits
   assign seen = (w.taps != 24'h000000) && (w.taps != 24'hffffff);

   always_ff @(posedge clk) begin
      if (srst) begin
         flags <= `APW_FLAGS_RST;
      end else if (seen) begin
         flags <= risk;
      end
   end
   assign w.flags = flags;

   // ==========================================
   // capture at the selected position
   assign capt = w.taps[w.sel];
   always_ff @(posedge clk) begin
      if (srst) begin
         capt_q   <= 1'b0;
         w.ref_edge <= 1'b0;
      end else begin
         capt_q   <= capt;
         w.ref_edge <= capt & ~capt_q;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   edge_flags_a: assert property (w.flags[0] && w.flags[23])
      else $error("edge window flags not set");
   flag_map_a: assert property (seen |=> w.flags[12] == $past(risk[12]))
      else $error("window flag does not follow tap comparison");
   capt_pos_a: assert property ($rose(w.taps[w.sel]) && $stable(w.sel) |=> w.ref_edge)
      else $error("reference not captured at selected position");
endmodule

/* File: rtl/apw_top.sv */
// Behaviour
// - sampling clock path gets an adjustable delay to align or interleave devices
// - delay is clock inversion plus 256-step coarse plus 256-step fine
// - settings change live and shift lane clock, strobe and data alike
// - with ramping on, coarse delay walks step by step to the new value
// - ramp speed: one step per 256 cycles slow, four per 256 fast
// - ramp enable turns ramping on; each coarse write that differs from the present coarse value starts a new ramp
// - reference is captured by a deterministic clock edge every time
// - single-channel mode samples both edges, doubling the reference window
// - a set of delayed clock positions is offered for sampling the reference
// - reference position is detected and held as multi-bit window flags
// - each flag is 1 at a risky position, 0 at a valid one
// - capture select is the index of the chosen flag bit
// - 24 positions reported, only 0 to 15 selectable
// - flags 0 and 23 always read as 1
// - step refine 0 gives coarse position spacing, 1 gives fine
// - reference resets dividers and strobe; periodic rate divides frame rate
`timescale 1ns/1ns
`include "apw_defines.svh"
module apw_top (
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        SRST,
   // register port
   input  wire logic [11:0] REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_WDATA,
   output logic      [7:0]  REG_RDATA,
   // reference samples from the delayed capture positions
   input  wire logic [23:0] REF_TAPS,
   // delay line controls
   output logic             DELAY_INVERT,
   output logic      [7:0]  DELAY_COARSE,
   output logic      [7:0]  DELAY_FINE,
   output logic             DUAL_EDGE_SAMPLE,
   output logic             TAP_STEP_FINE,
   // frame timing
   output logic             LANE_STROBE,
   output logic             REF_CAPTURED
);
   // ==========================================
   // declarations
   apw_win_if                 win ();
   logic [7:0]                capt_ctrl;
   logic                      clock_invert_delay;
   logic [7:0]                coarse_delay_setting;
   logic [7:0]                fine_delay_setting;
   logic                      delay_ramp_enable;
   logic                      delay_ramp_speed;
   logic [7:0]                coarse_eff;
   logic [7:0]                tick_cnt;
   logic                      ramp_tick;
   logic                      coarse_wr;
   logic                      coarse_step;
   apw_pkg::apw_ramp_state_t  ramp_state;
   apw_pkg::apw_ramp_state_t  next_ramp_state;
   logic [7:0]                frame_cnt;
   logic [7:0]                next_rdata;

   assign coarse_wr = REG_WR && (REG_ADDR == `APW_OFS_DLY_COARSE);

   // ==========================================
   // control registers
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         capt_ctrl <= `APW_CAPT_CTRL_RST;
      end else if (REG_WR && REG_ADDR == `APW_OFS_CAPT_CTRL) begin
         capt_ctrl <= {2'h0, REG_WDATA[5:0]};
      end
   end

   // all three delay parts are applied live, no quiet period needed
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         clock_invert_delay <= 1'b0;
         fine_delay_setting <= `APW_DLY_RST;
      end else if (REG_WR && REG_ADDR == `APW_OFS_DLY_INV) begin
         clock_invert_delay <= REG_WDATA[0];
      end else if (REG_WR && REG_ADDR == `APW_OFS_DLY_FINE) begin
         fine_delay_setting <= REG_WDATA;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         coarse_delay_setting <= `APW_DLY_RST;
      end else if (coarse_wr) begin
         coarse_delay_setting <= REG_WDATA;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         delay_ramp_enable <= 1'b0;
         delay_ramp_speed  <= 1'b0;
      end else if (REG_WR && REG_ADDR == `APW_OFS_RAMP_CTRL) begin
         delay_ramp_enable <= REG_WDATA[`APW_RAMP_EN_BIT];
         delay_ramp_speed  <= REG_WDATA[`APW_RAMP_FAST_BIT];
      end
   end

   // ==========================================
   // coarse delay ramp
   // the tick counter restarts on every coarse write so a new ramp
   // always waits a full interval before its first step
   always_ff @(posedge CORE_CLK) begin
      if (SRST || coarse_wr) begin
         tick_cnt <= 8'h00;
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
      end
   end

   assign ramp_tick = delay_ramp_speed ? (tick_cnt[5:0] == 6'h3f)
                                       : (tick_cnt == 8'hff);
   assign coarse_step = (ramp_state == apw_pkg::RAMP_MOVE) && ramp_tick && !coarse_wr
                        && delay_ramp_enable && (coarse_eff != coarse_delay_setting);

   always_comb begin
      next_ramp_state = ramp_state;
      case (ramp_state)
         apw_pkg::RAMP_IDLE: begin
            if (delay_ramp_enable && coarse_wr && REG_WDATA != coarse_eff) begin
               next_ramp_state = apw_pkg::RAMP_MOVE;
            end
         end
         apw_pkg::RAMP_MOVE: begin
            // writing back the present value leaves nothing to walk, so the
            // busy flag must drop instead of waiting for a step that never comes
            if (!delay_ramp_enable || (coarse_wr && REG_WDATA == coarse_eff)) begin
               next_ramp_state = apw_pkg::RAMP_IDLE;
            end else if (coarse_step && coarse_eff == 8'(
                coarse_delay_setting + (coarse_eff < coarse_delay_setting ? 8'hff : 8'h01))) begin
               next_ramp_state = apw_pkg::RAMP_IDLE;
            end
         end
         default: next_ramp_state = apw_pkg::RAMP_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         ramp_state <= apw_pkg::RAMP_IDLE;
      end else begin
         ramp_state <= next_ramp_state;
      end
   end

   // without ramping the coarse value jumps at once; turning ramping off
   // mid-walk also jumps, which may glitch the clock briefly
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         coarse_eff <= `APW_DLY_RST;
      end else if (!delay_ramp_enable) begin
         coarse_eff <= coarse_wr ? REG_WDATA : coarse_delay_setting;
      end else if (coarse_step) begin
         if (coarse_eff < coarse_delay_setting) begin
            coarse_eff <= coarse_eff + 8'h01;
         end else begin
            coarse_eff <= coarse_eff - 8'h01;
         end
      end
   end

   // ==========================================
   // delay line outputs
   // one delay feeds sampling and lane timing, so lanes move together
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         DELAY_INVERT     <= 1'b0;
         DELAY_COARSE     <= `APW_DLY_RST;
         DELAY_FINE       <= `APW_DLY_RST;
         DUAL_EDGE_SAMPLE <= 1'b0;
         TAP_STEP_FINE    <= 1'b0;
      end else begin
         DELAY_INVERT     <= clock_invert_delay;
         DELAY_COARSE     <= coarse_eff;
         DELAY_FINE       <= fine_delay_setting;
         DUAL_EDGE_SAMPLE <= capt_ctrl[`APW_SINGLE_BIT];
         TAP_STEP_FINE    <= capt_ctrl[`APW_ZOOM_BIT];
      end
   end

   // ==========================================
   // reference windowing
   assign win.taps   = REF_TAPS;
   assign win.sel    = capt_ctrl[`APW_SEL_MSB:0];
   assign win.single = capt_ctrl[`APW_SINGLE_BIT];

   apw_window u_window (
      .clk  (CORE_CLK),
      .srst (SRST),
      .w    (win.win)
   );

   // ==========================================
   // frame divider and strobe
   // a captured reference restarts the divider so every device lines up
   always_ff @(posedge CORE_CLK) begin
      if (SRST || win.ref_edge) begin
         frame_cnt <= 8'h00;
      end else if (frame_cnt == `APW_FRAME_LEN - 8'd1) begin
         frame_cnt <= 8'h00;
      end else begin
         frame_cnt <= frame_cnt + 8'h01;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         LANE_STROBE  <= 1'b0;
         REF_CAPTURED <= 1'b0;
      end else begin
         LANE_STROBE  <= !win.ref_edge && (frame_cnt == `APW_FRAME_LEN - 8'd1);
         REF_CAPTURED <= win.ref_edge;
      end
   end

   // ==========================================
   // register reads
   always_comb begin
      next_rdata = 8'h00;
      if (REG_ADDR == `APW_OFS_CAPT_CTRL) begin
         next_rdata = capt_ctrl;
      end else if (REG_ADDR == `APW_OFS_FLAGS_LOW) begin
         next_rdata = win.flags[7:0];
      end else if (REG_ADDR == `APW_OFS_FLAGS_MID) begin
         next_rdata = win.flags[15:8];
      end else if (REG_ADDR == `APW_OFS_FLAGS_HIGH) begin
         next_rdata = win.flags[23:16];
      end else if (REG_ADDR == `APW_OFS_DLY_INV) begin
         next_rdata = {7'h00, clock_invert_delay};
      end else if (REG_ADDR == `APW_OFS_DLY_COARSE) begin
         next_rdata = coarse_delay_setting;
      end else if (REG_ADDR == `APW_OFS_DLY_FINE) begin
         next_rdata = fine_delay_setting;
      end else if (REG_ADDR == `APW_OFS_RAMP_CTRL) begin
         next_rdata = {5'h00, ramp_state == apw_pkg::RAMP_MOVE,
                       delay_ramp_speed, delay_ramp_enable};
      end else if (REG_ADDR == `APW_OFS_COARSE_EFF) begin
         next_rdata = coarse_eff;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= next_rdata;
      end
   end

   // ==========================================
   // checks
   // cycles since the last coarse write or step; saturates so a long idle
   // spell cannot wrap round and fake a correct spacing
   logic [8:0] gap;
   always_ff @(posedge CORE_CLK) begin
      if (SRST || coarse_wr || coarse_step) begin
         gap <= 9'h001;
      end else if (gap != 9'h1ff) begin
         gap <= gap + 9'h001;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   sequence s_ramp_write;
      delay_ramp_enable && coarse_wr;
   endsequence
   sequence s_unit_move;
      (DELAY_COARSE == $past(DELAY_COARSE) + 8'h01) ||
      (DELAY_COARSE == $past(DELAY_COARSE) - 8'h01) || $stable(DELAY_COARSE);
   endsequence
   // rest of a frame with no capture restarting the divider
   sequence s_quiet_frame;
      !win.ref_edge [*7];
   endsequence

   ramp_unit_step_a: assert property (delay_ramp_enable && $past(delay_ramp_enable, 2)
      && !$past(coarse_wr, 2) |-> s_unit_move)
      else $error("ramped coarse delay moved by more than one step");
   ramp_slow_gap_a: assert property (coarse_step && !delay_ramp_speed
      |-> gap == `APW_SLOW_PERIOD)
      else $error("slow ramp step spacing is not 256 cycles");
   ramp_fast_gap_a: assert property (coarse_step && delay_ramp_speed
      && $stable(delay_ramp_speed) |-> gap == `APW_FAST_PERIOD || gap == 9'h1ff)
      else $error("fast ramp step spacing is not 64 cycles");
   ramp_enter_a: assert property (s_ramp_write ##0 REG_WDATA != coarse_eff
      |=> ramp_state == apw_pkg::RAMP_MOVE)
      else $error("coarse write did not start a ramp");
   ramp_hold_a: assert property (s_ramp_write |=> $stable(coarse_eff) [*8])
      else $error("coarse delay moved too soon after a ramp write");
   jump_a: assert property (!delay_ramp_enable && coarse_wr
      |=> ##1 DELAY_COARSE == $past(REG_WDATA, 2))
      else $error("coarse delay did not jump with ramping off");
   strobe_reset_a: assert property (win.ref_edge |=> !LANE_STROBE [*8])
      else $error("strobe not restarted by reference");
   flags_read_a: assert property (REG_RD && REG_ADDR == `APW_OFS_FLAGS_HIGH
      |=> REG_RDATA[7])
      else $error("flag 23 read back as 0");
   sel_range_a: assert property (win.sel == capt_ctrl[3:0] && capt_ctrl[7:6] == 2'h0)
      else $error("capture select out of range");

   // ramp bookkeeping
   ramp_off_idle_a: assert property (!delay_ramp_enable
      |=> ramp_state == apw_pkg::RAMP_IDLE)
      else $error("ramp busy while ramping is off");
   ramp_done_a: assert property (coarse_step && next_ramp_state == apw_pkg::RAMP_IDLE
      |=> coarse_eff == coarse_delay_setting)
      else $error("ramp ended short of the written coarse value");
   ramp_dir_a: assert property (coarse_step && coarse_eff < coarse_delay_setting
      |=> coarse_eff == $past(coarse_eff) + 8'h01)
      else $error("ramp stepped away from the written coarse value");
   coarse_out_a: assert property (1'b1
      |=> DELAY_COARSE == $past(coarse_eff))
      else $error("coarse delay output does not follow the ramp");
   fine_out_a: assert property (1'b1
      |=> DELAY_FINE == $past(fine_delay_setting))
      else $error("fine delay output does not follow its setting");
   dual_edge_a: assert property (1'b1
      |=> DUAL_EDGE_SAMPLE == $past(capt_ctrl[`APW_SINGLE_BIT]))
      else $error("dual edge output does not follow its setting");
   step_fine_a: assert property (1'b1
      |=> TAP_STEP_FINE == $past(capt_ctrl[`APW_ZOOM_BIT]))
      else $error("step refine output does not follow its setting");

   // frame strobe and capture pulse
   strobe_gap_a: assert property (LANE_STROBE
      |=> !LANE_STROBE [*7])
      else $error("strobe came back inside one frame");
   strobe_frame_a: assert property (LANE_STROBE && !win.ref_edge ##1 s_quiet_frame
      |=> LANE_STROBE)
      else $error("strobe missing at the end of a frame");
   capt_pulse_a: assert property (REF_CAPTURED
      |=> !REF_CAPTURED)
      else $error("capture pulse longer than one cycle");
   rdata_hold_a: assert property (!REG_RD
      |=> $stable(REG_RDATA))
      else $error("read data changed without a read");
endmodule

/* File: dv/apw_ref_src.sv */
`timescale 1ns/1ns
// ==========================================
// clock source model: reference as seen by the delayed capture positions
module apw_ref_src (
   // clock
   input  wire logic        clk,
   // bench commands
   input  wire logic        level,
   input  wire logic [4:0]  pos,
   // samples at the 24 positions
   output logic      [23:0] taps
);
   // larger delay samples later, so positions at and above pos see the rise
   always_ff @(posedge clk) begin
      taps <= level ? (24'hffffff << pos) : 24'h000000;
   end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
   // ==========================================
   // signals
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic [23:0] ref_taps;
   logic        ref_level = 1'b0;
   logic [4:0]  ref_pos = 5'h00;
   logic        dly_inv, dual_edge, step_fine, lane_strobe, ref_captured;
   logic [7:0]  dly_coarse, dly_fine;
   int          n_fail = 0;
   int          comparisons = 0;
   int          cycles = 0;
   logic [7:0]  v, c, f;
   logic [4:0]  p;
   int          n, per;

   always #4 core_clk = ~core_clk;

   apw_ref_src u_apw_ref_src (.clk(core_clk), .level(ref_level), .pos(ref_pos), .taps(ref_taps));

   apw_top u_apw_top (
      .CORE_CLK(core_clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REF_TAPS(ref_taps),
      .DELAY_INVERT(dly_inv), .DELAY_COARSE(dly_coarse), .DELAY_FINE(dly_fine),
      .DUAL_EDGE_SAMPLE(dual_edge), .TAP_STEP_FINE(step_fine),
      .LANE_STROBE(lane_strobe), .REF_CAPTURED(ref_captured)
   );

   // ==========================================
   // helpers
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // a hung wait ends the run here instead of stalling forever
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdchk(string what, logic [11:0] a, logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check(what, {16'h0000, reg_rdata}, {16'h0000, exp});
   endtask

   // a transition between neighbours marks both as risky; the ends are always risky
   function automatic logic [23:0] exp_flags(logic [4:0] q);
      logic [23:0] t;
      t = 24'hffffff << q;
      return (t ^ {t[22:0], 1'b0}) | (t ^ {1'b0, t[23:1]}) | 24'h800001;
   endfunction

   task automatic flags_chk(logic [23:0] e);
      rdchk("flags_low", 12'h02c, e[7:0]);
      rdchk("flags_mid", 12'h02d, e[15:8]);
      rdchk("flags_high", 12'h02e, e[23:16]);
   endtask

   // ==========================================
   // tests
   initial begin
      void'($urandom(3));
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      cyc(1);
      check("reset_outputs", {6'h00, dly_inv, dly_coarse, dly_fine, dual_edge}, 24'h000000);
      rdchk("capt_ctrl_rst", 12'h029, 8'h10);
      rdchk("unmapped", 12'h100, 8'h00);
      flags_chk(24'h800001);
      $display("test reset done");

      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 8'hff : 8'($urandom);
         c = (k == 0) ? 8'hff : 8'($urandom);
         f = (k == 1) ? 8'h00 : 8'($urandom);
         wr(12'h030, v);
         wr(12'h031, c);
         wr(12'h032, f);
         cyc(1);
         check("invert", {23'h0, dly_inv}, {23'h0, v[0]});
         check("coarse", {16'h0, dly_coarse}, {16'h0, c});
         check("fine", {16'h0, dly_fine}, {16'h0, f});
         rdchk("coarse_eff", 12'h034, c);
         rdchk("fine_rb", 12'h032, f);
      end
      $display("test delay done");

      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 8'hff : 8'($urandom);
         wr(12'h029, v);
         cyc(1);
         check("step_fine", {23'h0, step_fine}, {23'h0, v[4]});
         check("dual_edge", {23'h0, dual_edge}, {23'h0, v[5]});
         rdchk("capt_ctrl", 12'h029, v & 8'h3f);
      end
      $display("test capture control done");

      for (int k = 0; k < 6; k++) begin
         p = (k == 0) ? 5'd1 : (k == 1) ? 5'd23 : 5'(1 + $urandom % 23);
         @(posedge core_clk);
         ref_pos <= p;
         ref_level <= 1'b1;
         cyc(4);
         wr(12'h02c, 8'h55);
         flags_chk(exp_flags(p));
         @(posedge core_clk);
         ref_level <= 1'b0;
         cyc(4);
         flags_chk(exp_flags(p));
      end
      $display("test window done");

      for (int k = 0; k < 6; k++) begin
         v = (k == 0) ? 8'h0f : 8'($urandom % 15);
         p = 5'(v) + 5'(k[0]);
         wr(12'h029, 8'h10 | v);
         cyc(3);
         @(posedge core_clk);
         ref_pos <= p;
         ref_level <= 1'b1;
         n = 0;
         while (ref_captured !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
         end
         check("capture_delay", 24'(n), k[0] ? 24'd10 : 24'd3);
         n = 0;
         while (lane_strobe !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
         end
         cyc(1);
         n = 1;
         while (lane_strobe !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
         end
         check("strobe_period", 24'(n), 24'd8);
         @(posedge core_clk);
         ref_level <= 1'b0;
         cyc(2);
      end
      $display("test capture done");

      c = 8'($urandom % 250);
      wr(12'h033, 8'h00);
      wr(12'h031, c);
      cyc(1);
      check("ramp_off", {16'h0, dly_coarse}, {16'h0, c});
      for (int k = 1; k >= 0; k--) begin
         per = k ? 64 : 256;
         wr(12'h033, {6'h00, k[0], 1'b1});
         wr(12'h031, k ? c + 8'd2 : c);
         rdchk("ramp_busy", 12'h033, {5'h00, 1'b1, k[0], 1'b1});
         cyc(per - 12);
         check("ramp_hold", {16'h0, dly_coarse}, {16'h0, k ? c : c + 8'd2});
         cyc(12);
         check("ramp_step1", {16'h0, dly_coarse}, {16'h0, c + 8'd1});
         cyc(per);
         check("ramp_step2", {16'h0, dly_coarse}, {16'h0, k ? c + 8'd2 : c});
         cyc(per);
         check("ramp_end", {16'h0, dly_coarse}, {16'h0, k ? c + 8'd2 : c});
         rdchk("ramp_idle", 12'h033, {6'h00, k[0], 1'b1});
      end
      wr(12'h033, 8'h03);
      wr(12'h031, c + 8'd3);
      cyc(70);
      wr(12'h033, 8'h00);
      cyc(3);
      check("ramp_abort", {16'h0, dly_coarse}, {16'h0, c + 8'd3});
      $display("test ramp done");
      tally_and_finish();
   end
endmodule
